// *** logic/spq_defs.svh ***
// register map, field positions, reset values and divider constants
`ifndef SPQ_DEFS_SVH
`define SPQ_DEFS_SVH
// register word addresses on the plain register port
`define SPQ_ADDR_STAT 2'h0
`define SPQ_ADDR_CON1 2'h1
`define SPQ_ADDR_CON2 2'h2
`define SPQ_ADDR_DATA 2'h3
// port_status_control fields
`define SPQ_ST_ON 15
`define SPQ_ST_IDLE 13
`define SPQ_ST_SHE 7
`define SPQ_ST_OVR 6
`define SPQ_ST_RXE 5
`define SPQ_ST_SEL_HI 4
`define SPQ_ST_SEL_LO 2
`define SPQ_ST_TXF 1
`define SPQ_ST_RXF 0
// port_control_one fields
`define SPQ_C1_CLKOFF 12
`define SPQ_C1_DOOFF 11
`define SPQ_C1_WIDTH 10
`define SPQ_C1_SMP 9
`define SPQ_C1_EDGE 8
`define SPQ_C1_SELECT_PIN_USE 7
`define SPQ_C1_IDLE 6
`define SPQ_C1_MST 5
`define SPQ_C1_FINE_HI 4
`define SPQ_C1_FINE_LO 2
`define SPQ_C1_COARSE_HI 1
`define SPQ_C1_COARSE_LO 0
`define SPQ_C1_MASK 16'h1FFF
// port_control_two fields
`define SPQ_C2_FRM 15
`define SPQ_C2_FSD 14
`define SPQ_C2_FPOL 13
`define SPQ_C2_FALIGN 1
`define SPQ_C2_QMODE 0
`define SPQ_C2_MASK 16'hE003
// reset values
`define SPQ_REG_RESET 16'h0000
`define SPQ_PIN_RESET 3'h1
// queue depth in enhanced mode
`define SPQ_DEPTH 8
// divider ratios
`define SPQ_COARSE_11 10'h001
`define SPQ_COARSE_10 10'h004
`define SPQ_COARSE_01 10'h010
`define SPQ_COARSE_00 10'h040
`define SPQ_FINE_BASE 4'h8
`define SPQ_MIN_PERIOD 10'h002
`define SPQ_COUNT_MAX 3'h7
`endif

// *** logic/spq_pkg.sv ***
// types shared by the serial port design
package spq_pkg;
   // master sequencer, one-hot
   typedef enum logic [2:0] {
      spq_st_idle = 3'b001,
      spq_st_lead = 3'b010,
      spq_st_bits = 3'b100
   } spq_state_t;
   // interrupt source selector codes
   typedef enum logic [2:0] {
      spq_irq_rx_empty = 3'h0,
      spq_irq_rx_avail = 3'h1,
      spq_irq_rx_3q = 3'h2,
      spq_irq_rx_full = 3'h3,
      spq_irq_tx_slot = 3'h4,
      spq_irq_tx_done = 3'h5,
      spq_irq_tx_empty = 3'h6,
      spq_irq_tx_full = 3'h7
   } spq_irq_sel_t;
   // raw pin levels coming in
   typedef struct packed {
      logic shift_clock_pin;
      logic data_in_pin;
      logic select_sync_pin;
   } spq_pins_in_t;
   // pin levels and enables going out
   typedef struct packed {
      logic shift_clock_pin;
      logic shift_clock_oe;
      logic data_out_pin;
      logic data_out_oe;
      logic select_sync_pin;
      logic select_sync_oe;
   } spq_pins_out_t;
endpackage

// *** logic/spq_port.sv ***
// serial port with shift register, holding buffers or queues, and framing
// Operation
// R1: module_on enables port and claims pins
// R2: transfer_count shows pending or unread words
// R3: shifter_empty high when shift register idle
// R4: overrun sets on unread data, discards word
// R5: receive_queue_empty high when queue empty
// R6: selector codes 110, 101, 100 raise interrupt
// R7: selector codes 011, 010 raise on fill
// R8: standard transmit_full set on write, cleared on load
// R9: enhanced transmit_full tracks last free slot
// R10: standard receive_full set on word, cleared on read
// R11: enhanced receive_full tracks last unread slot
// R12: software keeps sample_phase clear as slave
// R13: software clears clock edge bit when framed
// R14: slave with clock edge set needs select
// R15: software configures, clears overrun, then enables
// R16: queue_mode set before enable selects queues
// R17: master starts shifting on data window write
// R18: fine divider divides by eight minus code
// R19: coarse divider divides by 1,4,16,64
// R20: framing_on turns select into frame sync
// R21: sync direction and level bits obeyed
// R22: sync alignment places pulse with or before
// R23: eight-deep queues, single buffer in standard
// R24: three-pin and two-pin operation supported
// R25: word_width picks 16 or 8 bits
// R26: shift clock is clock over divider product; a product of one runs as two
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "spq_defs.svh"
module spq_port #(
   parameter int DEPTH = `SPQ_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire spq_pkg::spq_pins_in_t pins_in,
   output spq_pkg::spq_pins_out_t pins_out,
   output logic port_interrupt_flag
);
   localparam int CW = $clog2(DEPTH + 1); // queue count width
   localparam int PW = $clog2(DEPTH); // queue pointer width, depth 2^n
   // software-visible control
   logic module_on;
   logic idle_halt; // stored only; no idle request reaches this block
   logic receive_overrun;
   logic [2:0] interrupt_source_select;
   logic [15:0] con1;
   logic [15:0] con2;
   // pin synchronisers: bit 2 clock, bit 1 data in, bit 0 select
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_c;
   logic [2:0] pin_level;
   logic sck_prev;
   // queues
   logic [15:0] tx_mem [DEPTH];
   logic [15:0] rx_mem [DEPTH];
   logic [PW-1:0] tx_rd, tx_wr, rx_rd, rx_wr;
   logic [CW-1:0] tx_count, rx_count, cap;
   // shifter
   spq_pkg::spq_state_t state;
   logic [9:0] div_cnt;
   logic [4:0] samp_cnt;
   logic [15:0] tx_sr, rx_sr, next_rx;
   logic tx_loaded; // a word sits in the shift register
   logic frame_act; // framed slave saw its sync pulse
   logic lvl_prev;
   // decoded control fields
   logic master, word16, cke, idle_lvl, framing, sync_in, sync_pol, align;
   logic queue_mode, sync_seen, selected, gate, lead_edge, trail_edge;
   logic [9:0] coarse_ratio, period, half;
   logic [3:0] fine_ratio;
   logic [4:0] last_bit;
   logic m_sample, s_sample, m_shift, s_shift, sample_pulse, shift_pulse;
   logic word_done, period_end, load_go, tx_push, rx_push, rx_pop, overrun_set;
   logic irq_event, irq_level, sync_drive;
   logic [CW-1:0] shown;
   assign master = con1[`SPQ_C1_MST];
   assign word16 = con1[`SPQ_C1_WIDTH];
   assign cke = con1[`SPQ_C1_EDGE];
   assign idle_lvl = con1[`SPQ_C1_IDLE];
   assign framing = con2[`SPQ_C2_FRM];
   assign sync_in = con2[`SPQ_C2_FSD];
   assign sync_pol = con2[`SPQ_C2_FPOL];
   assign align = con2[`SPQ_C2_FALIGN];
   assign queue_mode = con2[`SPQ_C2_QMODE];
   assign cap = queue_mode ? CW'(DEPTH) : CW'(1); // [R23]
   assign last_bit = word16 ? 5'h0F : 5'h07; // [R25]

   // shift clock period in system clocks: coarse times fine
   always_comb begin
      unique case (con1[`SPQ_C1_COARSE_HI:`SPQ_C1_COARSE_LO])
         2'h3: coarse_ratio = `SPQ_COARSE_11; // [R19]
         2'h2: coarse_ratio = `SPQ_COARSE_10;
         2'h1: coarse_ratio = `SPQ_COARSE_01;
         2'h0: coarse_ratio = `SPQ_COARSE_00;
      endcase
      // [R18]
      fine_ratio = `SPQ_FINE_BASE -
         {1'b0, con1[`SPQ_C1_FINE_HI:`SPQ_C1_FINE_LO]};
      period = 10'(coarse_ratio * {6'h00, fine_ratio}); // [R26]
      // 1:1 overall cannot make two edges; it runs as 2:1 instead
      if (period < `SPQ_MIN_PERIOD) begin
         period = `SPQ_MIN_PERIOD;
      end
      half = period >> 1;
   end

   // three-stage pin capture; a level counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync_a <= `SPQ_PIN_RESET;
         sync_b <= `SPQ_PIN_RESET;
         sync_c <= `SPQ_PIN_RESET;
         pin_level <= `SPQ_PIN_RESET;
         sck_prev <= 1'b0;
      end else begin
         sync_a <= {pins_in.shift_clock_pin, pins_in.data_in_pin,
                    pins_in.select_sync_pin};
         sync_b <= sync_a;
         sync_c <= sync_b;
         pin_level <= (sync_c & ~(sync_b ^ sync_c)) |
                      (pin_level & (sync_b ^ sync_c));
         sck_prev <= pin_level[2];
      end
   end

   // slave edge and select decode
   always_comb begin
      lead_edge = (sck_prev == idle_lvl) && (pin_level[2] != idle_lvl);
      trail_edge = (sck_prev != idle_lvl) && (pin_level[2] == idle_lvl);
      sync_seen = (pin_level[0] == sync_pol); // [R21]
      if (framing) begin
         selected = frame_act; // [R20]
      end else if (con1[`SPQ_C1_SELECT_PIN_USE]) begin
         selected = !pin_level[0]; // active-low select
      end else begin
         selected = 1'b1; // three-pin slave, always listening [R24]
      end
      // edges under a preceding sync pulse belong to no bit [R22]
      gate = !framing || align || !sync_seen;
   end

   // sample and shift events for both roles
   always_comb begin
      period_end = (div_cnt == period - 10'h001);
      // master samples mid-bit, or at bit end with sample_phase set
      m_sample = (state == spq_pkg::spq_st_bits) &&
         (con1[`SPQ_C1_SMP] ? period_end : (div_cnt == half));
      m_shift = (state == spq_pkg::spq_st_bits) && (div_cnt == 10'h000) &&
         (samp_cnt != 5'h00);
      s_sample = module_on && !master && selected && gate &&
         (cke ? lead_edge : trail_edge);
      s_shift = module_on && !master && selected && gate &&
         (samp_cnt != 5'h00) && (cke ? trail_edge : lead_edge);
      sample_pulse = master ? m_sample : s_sample;
      shift_pulse = master ? m_shift : s_shift;
      next_rx = {rx_sr[14:0], pin_level[1]};
      word_done = sample_pulse && (samp_cnt == last_bit);
      // [R17] master picks up a queued word as soon as one is there
      load_go = module_on && !tx_loaded && (tx_count != '0) &&
         (master ? (state == spq_pkg::spq_st_idle) : (samp_cnt == 5'h00));
      tx_push = reg_write && (reg_addr == `SPQ_ADDR_DATA) &&
         (tx_count < cap);
      rx_push = word_done && (rx_count < cap);
      overrun_set = word_done && (rx_count >= cap); // [R4]
      rx_pop = reg_read && (reg_addr == `SPQ_ADDR_DATA) && (rx_count != '0);
   end

   // control registers written by software
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         module_on <= 1'b0;
         idle_halt <= 1'b0;
         interrupt_source_select <= 3'h0;
         con1 <= `SPQ_REG_RESET;
         con2 <= `SPQ_REG_RESET;
      end else if (reg_write) begin
         if (reg_addr == `SPQ_ADDR_STAT) begin
            module_on <= reg_wdata[`SPQ_ST_ON]; // [R1]
            idle_halt <= reg_wdata[`SPQ_ST_IDLE];
            interrupt_source_select <=
               reg_wdata[`SPQ_ST_SEL_HI:`SPQ_ST_SEL_LO];
         end
         if (reg_addr == `SPQ_ADDR_CON1) begin
            con1 <= reg_wdata & `SPQ_C1_MASK;
         end
         if (reg_addr == `SPQ_ADDR_CON2) begin
            con2 <= reg_wdata & `SPQ_C2_MASK;
         end
      end
   end

   // overrun flag: hardware set wins over a software clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         receive_overrun <= 1'b0;
      end else if (overrun_set) begin
         receive_overrun <= 1'b1; // [R4]
      end else if (reg_write && (reg_addr == `SPQ_ADDR_STAT) &&
                   !reg_wdata[`SPQ_ST_OVR]) begin
         receive_overrun <= 1'b0;
      end
   end

   // transmit queue; a single slot in standard mode
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_rd <= '0;
         tx_wr <= '0;
         tx_count <= '0;
      end else begin
         if (tx_push) begin
            tx_wr <= tx_wr + PW'(1);
         end
         if (load_go) begin
            tx_rd <= tx_rd + PW'(1);
         end
         // full sets on the filling write, clears on the load [R8] [R9]
         tx_count <= tx_count + CW'(tx_push) - CW'(load_go);
      end
   end

   // receive queue; a new word beyond capacity is dropped [R4]
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_rd <= '0;
         rx_wr <= '0;
         rx_count <= '0;
      end else begin
         if (rx_push) begin
            rx_wr <= rx_wr + PW'(1);
         end
         if (rx_pop) begin
            rx_rd <= rx_rd + PW'(1);
         end
         // full sets on the filling word, clears on a read [R10] [R11]
         rx_count <= rx_count + CW'(rx_push) - CW'(rx_pop);
      end
   end

   // queue storage; data only, so no reset is needed
   always_ff @(posedge clk) begin
      if (tx_push) begin
         tx_mem[tx_wr] <= reg_wdata;
      end
      if (rx_push) begin
         // 8-bit words sit in the low byte [R25]
         rx_mem[rx_wr] <= word16 ? next_rx : {8'h00, next_rx[7:0]};
      end
   end

   // master sequencer and bit timing
   always_ff @(posedge clk) begin
      if (!reset_n || !module_on || !master) begin
         state <= spq_pkg::spq_st_idle;
         div_cnt <= 10'h000;
      end else begin
         unique case (state)
            spq_pkg::spq_st_idle: begin
               div_cnt <= 10'h000;
               if (load_go) begin
                  // early sync needs one extra bit time [R22]
                  state <= (framing && !align) ? spq_pkg::spq_st_lead :
                                                 spq_pkg::spq_st_bits;
               end
            end
            spq_pkg::spq_st_lead: begin
               div_cnt <= period_end ? 10'h000 : div_cnt + 10'h001;
               if (period_end) begin
                  state <= spq_pkg::spq_st_bits;
               end
            end
            spq_pkg::spq_st_bits: begin
               div_cnt <= period_end ? 10'h000 : div_cnt + 10'h001;
               if (period_end && (word_done || !tx_loaded)) begin
                  state <= spq_pkg::spq_st_idle;
               end
            end
         endcase
      end
   end

   // shift registers, bit count and slave frame tracking
   always_ff @(posedge clk) begin
      if (!reset_n || !module_on) begin
         tx_sr <= 16'h0000;
         rx_sr <= 16'h0000;
         samp_cnt <= 5'h00;
         tx_loaded <= 1'b0;
         frame_act <= 1'b0;
      end else begin
         if (load_go) begin
            tx_sr <= tx_mem[tx_rd];
            tx_loaded <= 1'b1;
         end else if (shift_pulse) begin
            tx_sr <= {tx_sr[14:0], 1'b0};
         end
         if (word_done) begin
            tx_loaded <= 1'b0;
            samp_cnt <= 5'h00;
            rx_sr <= 16'h0000;
         end else if (sample_pulse) begin
            samp_cnt <= samp_cnt + 5'h01;
            rx_sr <= next_rx;
         end else if (!master && !framing && !selected) begin
            samp_cnt <= 5'h00; // select released mid-word: abort it
         end
         // framed slave waits for its sync pulse [R21]
         if (word_done) begin
            frame_act <= 1'b0;
         end else if (framing && !master && sync_in && sync_seen &&
                      samp_cnt == 5'h00) begin
            frame_act <= 1'b1;
         end
      end
   end

   // pin drive; everything released while the port is off [R1] [R24]
   always_comb begin
      sync_drive = (state == spq_pkg::spq_st_lead) ||
         (align && state == spq_pkg::spq_st_bits && samp_cnt == 5'h00);
      pins_out.shift_clock_pin = idle_lvl;
      if (state == spq_pkg::spq_st_bits) begin
         pins_out.shift_clock_pin = idle_lvl ^
            (cke ? (div_cnt >= half) : (div_cnt < half));
      end
      pins_out.shift_clock_oe = module_on && master &&
         !con1[`SPQ_C1_CLKOFF];
      pins_out.data_out_pin = word16 ? tx_sr[15] : tx_sr[7];
      pins_out.data_out_oe = module_on && !con1[`SPQ_C1_DOOFF];
      pins_out.select_sync_pin = sync_drive ? sync_pol : !sync_pol;
      pins_out.select_sync_oe = module_on && framing && !sync_in; // [R21]
   end

   // interrupt source: events pass straight, levels on their rising edge
   always_comb begin
      irq_event = 1'b0;
      irq_level = 1'b0;
      if (!queue_mode) begin
         irq_event = word_done;
      end else begin
         unique case (spq_pkg::spq_irq_sel_t'(interrupt_source_select))
            spq_pkg::spq_irq_tx_full: irq_level = (tx_count >= cap);
            // [R6]
            spq_pkg::spq_irq_tx_empty:
               irq_event = load_go && (tx_count == CW'(1));
            spq_pkg::spq_irq_tx_done: irq_event = word_done;
            spq_pkg::spq_irq_tx_slot:
               irq_event = load_go && (tx_count == cap);
            // [R7]
            spq_pkg::spq_irq_rx_full: irq_level = (rx_count >= cap);
            spq_pkg::spq_irq_rx_3q:
               irq_level = ({rx_count, 2'b00} >= {1'b0, cap, 1'b0} +
                            {2'b00, cap});
            spq_pkg::spq_irq_rx_avail: irq_level = (rx_count != '0);
            spq_pkg::spq_irq_rx_empty: irq_level = (rx_count == '0);
         endcase
      end
   end

   // interrupt flag is a one-cycle pulse
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lvl_prev <= 1'b0;
         port_interrupt_flag <= 1'b0;
      end else begin
         lvl_prev <= irq_level;
         port_interrupt_flag <= module_on &&
            (irq_event || (irq_level && !lvl_prev)); // [R6] [R7]
      end
   end

   // count shown: pending as master, unread as slave, saturated at 7
   assign shown = master ? tx_count : rx_count; // [R2]

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!reset_n || !reg_read) begin
         reg_rdata <= 16'h0000;
      end else begin
         unique case (reg_addr)
            `SPQ_ADDR_STAT: begin
               reg_rdata <= 16'h0000;
               reg_rdata[`SPQ_ST_ON] <= module_on;
               reg_rdata[`SPQ_ST_IDLE] <= idle_halt;
               reg_rdata[10:8] <= (shown > CW'(`SPQ_COUNT_MAX)) ?
                  `SPQ_COUNT_MAX : shown[2:0]; // [R2]
               reg_rdata[`SPQ_ST_SHE] <= !tx_loaded && // [R3]
                  state == spq_pkg::spq_st_idle && samp_cnt == 5'h00;
               reg_rdata[`SPQ_ST_OVR] <= receive_overrun;
               reg_rdata[`SPQ_ST_RXE] <= (rx_count == '0); // [R5]
               reg_rdata[`SPQ_ST_SEL_HI:`SPQ_ST_SEL_LO] <=
                  interrupt_source_select;
               reg_rdata[`SPQ_ST_TXF] <= (tx_count >= cap); // [R8] [R9]
               reg_rdata[`SPQ_ST_RXF] <= (rx_count >= cap); // [R10] [R11]
            end
            `SPQ_ADDR_CON1: reg_rdata <= con1;
            `SPQ_ADDR_CON2: reg_rdata <= con2;
            `SPQ_ADDR_DATA: begin
               reg_rdata <= (rx_count != '0) ? rx_mem[rx_rd] : 16'h0000;
            end
         endcase
      end
   end
endmodule

// *** tb/spq_port_props.sv ***
// assertions on the serial port's top ports, with their bind
`timescale 1ns/1ps
`include "spq_defs.svh"
module spq_port_props #(
   parameter int DEPTH = `SPQ_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire spq_pkg::spq_pins_in_t pins_in,
   input wire spq_pkg::spq_pins_out_t pins_out,
   input wire logic port_interrupt_flag
);
   logic on_q; // module_on as software last wrote it
   logic [15:0] c1; // mirror of port_control_one
   logic [15:0] c2; // mirror of port_control_two
   logic [9:0] act; // cycles the shift clock has been away from idle
   logic [9:0] prod; // divider product
   logic [9:0] half; // expected active half of one bit
   logic idle; // idle level of the shift clock
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   assign idle = c1[`SPQ_C1_IDLE];
   assign prod = (10'h001 << {~c1[1:0], 1'h0}) * (10'h008 - c1[4:2]);
   // a product of one is run as two, so half never drops to zero
   assign half = (prod < 10'h002) ? 10'h001 : prod >> 1;
   // mirror writes; reserved bits masked as the design drops them
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         on_q <= 1'h0;
         c1 <= 16'h0000;
         c2 <= 16'h0000;
      end else if (reg_write) begin
         case (reg_addr)
            `SPQ_ADDR_STAT: on_q <= reg_wdata[`SPQ_ST_ON];
            `SPQ_ADDR_CON1: c1 <= reg_wdata & `SPQ_C1_MASK;
            `SPQ_ADDR_CON2: c2 <= reg_wdata & `SPQ_C2_MASK;
            default: ;
         endcase
      end
   end
   // length of the current active phase of the shift clock
   always_ff @(posedge clk) begin
      if (!reset_n || pins_out.shift_clock_pin == idle) begin
         act <= 10'h000;
      end else begin
         act <= act + 10'h001;
      end
   end
   AST_RD_IDLE: assert property (
      !$past(reg_read) |-> reg_rdata == 16'h0000)
      else $error("read data seen outside the answer cycle");
   AST_RD_STAT: assert property (
      $past(reg_read && reg_addr == `SPQ_ADDR_STAT) |->
      {reg_rdata[15:14], reg_rdata[12:11]} == {$past(on_q), 3'h0})
      else $error("status word enable or reserved bits wrong");
   AST_RD_CON1: assert property (
      $past(reg_read && reg_addr == `SPQ_ADDR_CON1) |->
      reg_rdata == $past(c1))
      else $error("control one read back wrong");
   AST_RD_CON2: assert property (
      $past(reg_read && reg_addr == `SPQ_ADDR_CON2) |->
      reg_rdata == $past(c2))
      else $error("control two read back wrong");
   AST_CLK_OE: assert property (
      pins_out.shift_clock_oe == (on_q && c1[5] && !c1[12]))
      else $error("shift clock enable wrong");
   AST_DO_OE: assert property (
      pins_out.data_out_oe == (on_q && !c1[11]))
      else $error("data out enable wrong");
   AST_SYNC_OE: assert property (
      pins_out.select_sync_oe == (on_q && c2[15] && !c2[14]))
      else $error("sync pin enable wrong");
   AST_OFF_IDLE: assert property (
      !on_q |-> pins_out.shift_clock_pin == idle)
      else $error("shift clock moves while port is off");
   AST_HALF: assert property (
      on_q && c1[5] && $fell(pins_out.shift_clock_pin != idle) |->
      act == half)
      else $error("shift clock active phase has wrong length");
   AST_IRQ_PULSE: assert property (
      $rose(port_interrupt_flag) |=> !port_interrupt_flag)
      else $error("interrupt longer than one cycle");
   cover property ($fell(pins_out.shift_clock_pin != idle));
   cover property (port_interrupt_flag);
   cover property ($past(reg_read && reg_addr == `SPQ_ADDR_DATA)
      && reg_rdata != 16'h0000);
endmodule
bind spq_port spq_port_props #(.DEPTH(DEPTH)) u_spq_port_props (
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .pins_in(pins_in), .pins_out(pins_out),
   .port_interrupt_flag(port_interrupt_flag));

// *** tb/spq_remote.sv ***
// remote slave model: answers each word the port clocks out
`timescale 1ns/1ps
module spq_remote (
   input wire logic reset_n,
   input wire logic sck,
   input wire logic sdo,
   output logic sdi,
   output logic [15:0] last_word,
   output logic [7:0] word_count
);
   logic [15:0] tx_sr; // word being returned
   logic [15:0] rx_sr; // word being taken in
   int bit_n = 0; // bits taken in this word
   initial begin
      sdi = 1'h0;
      last_word = 16'h0000;
      word_count = 8'h00;
   end
   // leading edge, clock idle low: present the next bit
   always @(posedge sck iff reset_n) begin
      if (bit_n == 0) begin
         tx_sr = 16'h3C5A ^ {word_count, ~word_count};
      end
      sdi = tx_sr[15];
      tx_sr = tx_sr << 1;
   end
   // trailing edge: take the port's bit, msb first
   always @(negedge sck iff reset_n) begin
      rx_sr = {rx_sr[14:0], sdo};
      bit_n++;
      if (bit_n == 16) begin
         bit_n = 0;
         last_word = rx_sr;
         word_count++;
         sdi = ~sdi; // a released line must not show a stale bit
      end
   end
endmodule

// *** tb/spq_port_test.sv ***
// self-checking bench for the serial port in master role
`timescale 1ns/1ps
`include "spq_defs.svh"
module spq_port_test;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'h0;
   logic reg_read = 1'h0;
   logic [15:0] reg_rdata;
   spq_pkg::spq_pins_in_t pins_in;
   spq_pkg::spq_pins_out_t pins_out;
   logic irq;
   logic sdi;
   logic [15:0] last_word;
   logic [7:0] word_count;
   logic [7:0] wc_q = 8'h00; // remote count seen last cycle
   logic [15:0] rd; // answer of the last read
   logic [15:0] sent [$]; // words written to the data window
   logic [15:0] rx_log [$]; // words the remote took in
   logic [31:0] seed = 32'h4A6F44A7;
   int err_total = 0;
   int checks = 0;
   int irq_n = 0;
   // remote clock input unused in master role; select held inactive
   assign pins_in = '{1'h0, sdi, 1'h1};
   spq_port #(.DEPTH(8)) u_spq_port (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .pins_in(pins_in), .pins_out(pins_out),
      .port_interrupt_flag(irq));
   spq_remote u_spq_remote (
      .reset_n(reset_n), .sck(pins_out.shift_clock_pin),
      .sdo(pins_out.data_out_pin), .sdi(sdi), .last_word(last_word),
      .word_count(word_count));
   initial begin
      forever #20 clk = ~clk;
   end
   // count interrupt pulses and log remote words
   always @(posedge clk) begin
      if (irq === 1'h1) irq_n++;
      if (word_count != wc_q) rx_log.push_back(last_word);
      wc_q <= word_count;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // word the remote returns as its n-th
   function automatic logic [15:0] rword(input logic [7:0] n);
      return 16'h3C5A ^ {n, ~n};
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got,
                      input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one strobe cycle, then one idle cycle so no strobe is set twice
   task automatic bus(input logic w, input logic [1:0] a,
                      input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= w;
      reg_read <= !w;
      @(posedge clk);
      reg_write <= 1'h0;
      reg_read <= 1'h0;
      #1 rd = reg_rdata;
      @(posedge clk);
   endtask
   task automatic send();
      seed = xs(seed);
      sent.push_back(seed[15:0]);
      bus(1'h1, `SPQ_ADDR_DATA, seed[15:0]);
   endtask
   task automatic stat(input logic [15:0] m, input logic [15:0] v);
      bus(1'h0, `SPQ_ADDR_STAT, 16'h0000);
      chk("status", rd & m, v);
   endtask
   // bounded wait on status bits
   task automatic poll(input logic [15:0] m, input logic [15:0] v);
      int i;
      for (i = 0; i < 3000; i++) begin
         bus(1'h0, `SPQ_ADDR_STAT, 16'h0000);
         if ((rd & m) === v) return;
      end
      chk("status wait", rd & m, v);
      conclude();
   endtask
   initial begin
      int i;
      repeat (12) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      for (i = 0; i < 4; i++) begin
         bus(1'h0, i[1:0], 16'h0000);
         chk("reset value", rd, (i == 0) ? 16'h00A0 : 16'h0000);
      end
      $display("reset test done");
      // 16-bit master, coarse 4, fine 4: configure, then enable
      bus(1'h1, `SPQ_ADDR_CON1, 16'h0432);
      bus(1'h1, `SPQ_ADDR_STAT, 16'h8000);
      send();
      send();
      stat(16'h0003, 16'h0002);
      poll(16'h0001, 16'h0001);
      bus(1'h0, `SPQ_ADDR_DATA, 16'h0000);
      chk("data word", rd, rword(0));
      stat(16'h0003, 16'h0002);
      poll(16'h0001, 16'h0001);
      bus(1'h0, `SPQ_ADDR_DATA, 16'h0000);
      chk("data word", rd, rword(1));
      send();
      poll(16'h0001, 16'h0001);
      send();
      poll(16'h0040, 16'h0040);
      bus(1'h0, `SPQ_ADDR_DATA, 16'h0000);
      chk("kept word", rd, rword(2));
      bus(1'h1, `SPQ_ADDR_STAT, 16'h8000);
      stat(16'h0041, 16'h0000);
      $display("standard test done");
      // queues on, interrupt on receive full
      bus(1'h1, `SPQ_ADDR_STAT, 16'h0000);
      bus(1'h1, `SPQ_ADDR_CON2, 16'h0001);
      bus(1'h1, `SPQ_ADDR_STAT, 16'h800C);
      irq_n = 0;
      for (i = 0; i < 9; i++) send();
      bus(1'h1, `SPQ_ADDR_DATA, 16'hFFFF);
      stat(16'h07E3, 16'h0722);
      poll(16'h0780, 16'h0080);
      stat(16'h07E3, 16'h00C1);
      chk("interrupts", irq_n[15:0], 16'h0001);
      for (i = 0; i < 8; i++) begin
         bus(1'h0, `SPQ_ADDR_DATA, 16'h0000);
         chk("queued word", rd, rword(i[7:0] + 8'h04));
         stat(16'h0021, (i == 7) ? 16'h0020 : 16'h0000);
      end
      bus(1'h0, `SPQ_ADDR_DATA, 16'h0000);
      chk("empty read", rd, 16'h0000);
      chk("remote count", 16'(rx_log.size()), 16'(sent.size()));
      for (i = 0; i < sent.size() && i < rx_log.size(); i++) begin
         chk("remote word", rx_log[i], sent[i]);
      end
      $display("enhanced test done");
      conclude();
   end
endmodule
